/* rtl/amp_params.svh */
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH

// ==========================================================
// register byte offsets on the apb slave
`define AMP_ADDR_CTRL       12'h000
`define AMP_ADDR_STATUS     12'h004
`define AMP_ADDR_EVENTS     12'h008
`define AMP_ADDR_W          12

// ==========================================================
// control register fields and reset value
`define AMP_CTRL_SOFT_MUTE  0
`define AMP_CTRL_CLEAR      1
`define AMP_CTRL_RESET      1'h0

// ==========================================================
// status register field positions
`define AMP_ST_CODE_LSB     0
`define AMP_ST_LIVE_UV      2
`define AMP_ST_LIVE_OT      3
`define AMP_ST_MUTE_N       4
`define AMP_ST_SHDN_N       5
`define AMP_ST_PIN_LO       6
`define AMP_ST_PIN_HI       7
`define AMP_ST_STATE_LSB    8

// ==========================================================
// event counter register fields
`define AMP_EV_UV_LSB       0
`define AMP_EV_OT_LSB       8
`define AMP_EV_W            8
`define AMP_EV_MAX          8'hff

// ==========================================================
// fault codes as {high bit, low bit} of the open-drain pair
`define AMP_CODE_NONE       2'h3
`define AMP_CODE_UV         2'h2
`define AMP_CODE_OT         2'h0

// ==========================================================
// pin synchroniser lanes and reset value
`define AMP_SYNC_W          6
`define AMP_SYNC_MUTE       0
`define AMP_SYNC_SHDN       1
`define AMP_SYNC_OT         2
`define AMP_SYNC_UV         3
`define AMP_SYNC_PIN_LO     4
`define AMP_SYNC_PIN_HI     5
`define AMP_SYNC_RESET      6'h00

`endif

/* rtl/amp_pkg.sv */
package amp_pkg;

  // ==========================================================
  // operating states of the power stage
  typedef enum logic [1:0] {
    ST_OFF,
    ST_MUTED,
    ST_FAULT,
    ST_RUN
  } amp_state_e;

  // ==========================================================
  // register select after address decode
  typedef enum logic [1:0] {
    SEL_CTRL,
    SEL_STATUS,
    SEL_EVENTS,
    SEL_NONE
  } reg_sel_e;

  typedef logic [1:0] fault_code_t;

endpackage : amp_pkg

/* rtl/amp_sync_if.sv */
`timescale 1ns/10ps
`include "amp_params.svh"

// ==========================================================
// raw pin levels in, synchronised levels out
interface amp_sync_if;
  logic [`AMP_SYNC_W-1:0] raw;
  logic [`AMP_SYNC_W-1:0] synced;

  modport src (input raw, output synced);
  modport dst (output raw, input synced);
endinterface : amp_sync_if

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
`include "amp_params.svh"

// ==========================================================
// two-flop synchroniser, one lane per asynchronous pin
module pin_sync (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // pin lanes
  amp_sync_if.src  bus
);

  logic [`AMP_SYNC_W-1:0] meta;
  logic [`AMP_SYNC_W-1:0] stable;
  // reset pattern held at lane width so each lane picks one bit
  localparam logic [`AMP_SYNC_W-1:0] sync_rst = `AMP_SYNC_RESET;

  genvar g;
  generate
    for (g = 0; g < `AMP_SYNC_W; g++)
    begin : g_lane
      // first stage feeds only the second stage
      always_ff @(posedge i_mclk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta[g]   <= sync_rst[g];
          stable[g] <= sync_rst[g];
        end
        else
        begin
          meta[g]   <= bus.raw[g];
          stable[g] <= meta[g];
        end
      end
    end
  endgenerate

  assign bus.synced = stable;

endmodule : pin_sync

/* rtl/amp_fault_mute_control.sv */
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "amp_params.svh"

// ==========================================================
// control and protection core of a stereo switching amplifier
module amp_fault_mute_control (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // host control pins, active low
  input  wire logic        i_mute_n,
  input  wire logic        i_shutdown_n,
  // analogue comparator levels
  input  wire logic        i_overtemp,
  input  wire logic        i_pump_undervoltage_fault,
  // open-drain fault pins
  input  wire logic        i_fault_code_low_bit,
  output logic             o_fault_code_low_bit,
  output logic             o_fault_code_low_bit_oe,
  input  wire logic        i_fault_code_high_bit,
  output logic             o_fault_code_high_bit,
  output logic             o_fault_code_high_bit_oe,
  // power stage control
  output logic             o_low_side_on,
  output logic             o_amp_enable,
  output logic             o_shutdown_mode
);

  // ==========================================================
  // decode helper, shared by the read and write paths
  function automatic amp_pkg::reg_sel_e decode_reg(input logic [11:0] addr);
    amp_pkg::reg_sel_e sel;
    sel = amp_pkg::SEL_NONE;
    case (addr)
      `AMP_ADDR_CTRL:   sel = amp_pkg::SEL_CTRL;
      `AMP_ADDR_STATUS: sel = amp_pkg::SEL_STATUS;
      `AMP_ADDR_EVENTS: sel = amp_pkg::SEL_EVENTS;
      default:          sel = amp_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode_reg

  // ==========================================================
  // declarations
  amp_sync_if             sync_bus ();
  logic                   mute_lvl;
  logic                   shdn_lvl;
  logic                   ot_lvl;
  logic                   uv_lvl;
  logic                   mute_prev;
  logic                   shdn_prev;
  logic                   ot_prev;
  logic                   uv_prev;
  logic                   pins_cycled;
  logic                   fault_live;
  amp_pkg::fault_code_t   fault_code;
  amp_pkg::fault_code_t   next_fault_code;
  amp_pkg::amp_state_e    state;
  amp_pkg::amp_state_e    next_state;
  logic [1:0]             state_num;
  logic                   soft_mute;
  logic                   soft_clear;
  logic [`AMP_EV_W-1:0]   uv_events;
  logic [`AMP_EV_W-1:0]   ot_events;
  amp_pkg::reg_sel_e      setup_sel;
  logic                   setup_phase;
  logic                   ack;
  logic                   err;
  logic                   wr_en;
  logic [31:0]            next_rdata;

  // ==========================================================
  // pin synchronisers
  // every pin is asynchronous to i_mclk, so all pass two flops
  assign sync_bus.raw = {i_fault_code_high_bit, i_fault_code_low_bit,
                         i_pump_undervoltage_fault, i_overtemp,
                         i_shutdown_n, i_mute_n};

  pin_sync u_pin_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .bus      (sync_bus.src)
  );

  assign mute_lvl = sync_bus.synced[`AMP_SYNC_MUTE];
  assign shdn_lvl = sync_bus.synced[`AMP_SYNC_SHDN];
  assign ot_lvl   = sync_bus.synced[`AMP_SYNC_OT];
  assign uv_lvl   = sync_bus.synced[`AMP_SYNC_UV];

  // ==========================================================
  // previous levels for edge detection
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mute_prev <= 1'h0;
      shdn_prev <= 1'h0;
      ot_prev   <= 1'h0;
      uv_prev   <= 1'h0;
    end
    else
    begin
      mute_prev <= mute_lvl;
      shdn_prev <= shdn_lvl;
      ot_prev   <= ot_lvl;
      uv_prev   <= uv_lvl;
    end
  end

  assign pins_cycled = (mute_lvl & ~mute_prev) | (shdn_lvl & ~shdn_prev) | soft_clear;
  assign fault_live  = ot_lvl | uv_lvl;

  // ==========================================================
  // retained fault code
  // a live fault always beats a clear arriving in the same cycle
  always_comb
  begin
    next_fault_code = fault_code;
    if (ot_lvl)
    begin
      next_fault_code = `AMP_CODE_OT;
    end
    else if (uv_lvl)
    begin
      // never downgrade a retained thermal code
      if (fault_code != `AMP_CODE_OT)
      begin
        next_fault_code = `AMP_CODE_UV;
      end
    end
    else if (pins_cycled)
    begin
      next_fault_code = `AMP_CODE_NONE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      fault_code <= `AMP_CODE_NONE;
    else
      fault_code <= next_fault_code;
  end

  // ==========================================================
  // open-drain fault pins
  // pull low for a zero
  assign o_fault_code_low_bit     = 1'h0;
  assign o_fault_code_high_bit    = 1'h0;
  assign o_fault_code_low_bit_oe  = ~fault_code[0];
  assign o_fault_code_high_bit_oe = ~fault_code[1];

  // ==========================================================
  // operating state
  // shutdown outranks faults, faults outrank mute
  always_comb
  begin
    next_state = amp_pkg::ST_RUN;
    if (!shdn_lvl)
      next_state = amp_pkg::ST_OFF;
    else if (fault_live)
      next_state = amp_pkg::ST_FAULT;
    else if (!mute_lvl || soft_mute)
      next_state = amp_pkg::ST_MUTED;
    else
      next_state = amp_pkg::ST_RUN;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state <= amp_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // ==========================================================
  // power stage outputs, registered alongside the state
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_low_side_on   <= 1'h0;
      o_amp_enable    <= 1'h0;
      o_shutdown_mode <= 1'h1;
    end
    else
    begin
      case (next_state)
        amp_pkg::ST_OFF:
        begin
          o_low_side_on   <= 1'h0;
          o_amp_enable    <= 1'h0;
          o_shutdown_mode <= 1'h1;
        end
        amp_pkg::ST_MUTED, amp_pkg::ST_FAULT:
        begin
          o_low_side_on   <= 1'h1;
          o_amp_enable    <= 1'h0;
          o_shutdown_mode <= 1'h0;
        end
        amp_pkg::ST_RUN:
        begin
          o_low_side_on   <= 1'h0;
          o_amp_enable    <= 1'h1;
          o_shutdown_mode <= 1'h0;
        end
        default:
        begin
          o_low_side_on   <= 1'h0;
          o_amp_enable    <= 1'h0;
          o_shutdown_mode <= 1'h1;
        end
      endcase
    end
  end

  // ==========================================================
  // fault event counters, saturating; a write to the events register clears them
  // an event in the clearing cycle is still counted as one
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      uv_events <= 8'h00;
      ot_events <= 8'h00;
    end
    else if (wr_en && setup_sel == amp_pkg::SEL_EVENTS)
    begin
      uv_events <= {7'h00, uv_lvl & ~uv_prev};
      ot_events <= {7'h00, ot_lvl & ~ot_prev};
    end
    else
    begin
      if (uv_lvl && !uv_prev && uv_events != `AMP_EV_MAX)
        uv_events <= uv_events + 8'h01;
      if (ot_lvl && !ot_prev && ot_events != `AMP_EV_MAX)
        ot_events <= ot_events + 8'h01;
    end
  end

  // ==========================================================
  // apb slave: decode at setup, answer in the first access cycle
  assign setup_phase = i_psel & ~i_penable;
  assign o_pready    = i_penable & ack;
  assign o_pslverr   = o_pready & err;
  assign wr_en       = i_psel & i_penable & o_pready & i_pwrite & ~err;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ack       <= 1'h0;
      err       <= 1'h0;
      setup_sel <= amp_pkg::SEL_NONE;
    end
    else
    begin
      ack <= setup_phase;
      if (setup_phase)
      begin
        setup_sel <= decode_reg(i_paddr);
        err       <= (decode_reg(i_paddr) == amp_pkg::SEL_NONE);
      end
    end
  end

  // ==========================================================
  // control register; clear bit is a self-resetting pulse
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      soft_mute  <= `AMP_CTRL_RESET;
      soft_clear <= 1'h0;
    end
    else
    begin
      soft_clear <= 1'h0;
      if (wr_en && setup_sel == amp_pkg::SEL_CTRL && i_pstrb[0])
      begin
        soft_mute  <= i_pwdata[`AMP_CTRL_SOFT_MUTE];
        soft_clear <= i_pwdata[`AMP_CTRL_CLEAR];
      end
    end
  end

  // ==========================================================
  // read data, captured at setup so it comes from a flop
  always_comb
  begin
    case (state)
      amp_pkg::ST_OFF:   state_num = 2'h0;
      amp_pkg::ST_MUTED: state_num = 2'h1;
      amp_pkg::ST_FAULT: state_num = 2'h2;
      amp_pkg::ST_RUN:   state_num = 2'h3;
      default:           state_num = 2'h0;
    endcase
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (decode_reg(i_paddr))
      amp_pkg::SEL_CTRL:
        next_rdata[`AMP_CTRL_SOFT_MUTE] = soft_mute;
      amp_pkg::SEL_STATUS:
      begin
        next_rdata[`AMP_ST_CODE_LSB +: 2]  = fault_code;
        next_rdata[`AMP_ST_LIVE_UV]        = uv_lvl;
        next_rdata[`AMP_ST_LIVE_OT]        = ot_lvl;
        next_rdata[`AMP_ST_MUTE_N]         = mute_lvl;
        next_rdata[`AMP_ST_SHDN_N]         = shdn_lvl;
        next_rdata[`AMP_ST_PIN_LO]         = sync_bus.synced[`AMP_SYNC_PIN_LO];
        next_rdata[`AMP_ST_PIN_HI]         = sync_bus.synced[`AMP_SYNC_PIN_HI];
        next_rdata[`AMP_ST_STATE_LSB +: 2] = state_num;
      end
      amp_pkg::SEL_EVENTS:
      begin
        next_rdata[`AMP_EV_UV_LSB +: `AMP_EV_W] = uv_events;
        next_rdata[`AMP_EV_OT_LSB +: `AMP_EV_W] = ot_events;
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_prdata <= 32'h0000_0000;
    else if (setup_phase && !i_pwrite)
      o_prdata <= next_rdata;
  end

endmodule : amp_fault_mute_control

/* tb/amp_fault_mute_control_asserts.sv */
`timescale 1ns/10ps
`include "amp_params.svh"

// ==========================================================
// port-level checker for the fault and mute core
module amp_fault_mute_control_asserts (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // pins and power stage
  input wire logic        i_mute_n,
  input wire logic        i_shutdown_n,
  input wire logic        i_overtemp,
  input wire logic        i_pump_undervoltage_fault,
  input wire logic        o_fault_code_low_bit_oe,
  input wire logic        o_fault_code_high_bit_oe,
  input wire logic        o_low_side_on,
  input wire logic        o_amp_enable,
  input wire logic        o_shutdown_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // short names; a pin needs two sync flops plus the state flop
  wire logic uv    = i_pump_undervoltage_fault;
  wire logic ot    = i_overtemp;
  wire logic quiet = !(i_psel && i_pwrite);

  // ==========================================================
  // fault codes and power stage
  uv_code_a: assert property (uv && i_shutdown_n |-> ##3 o_fault_code_low_bit_oe && o_low_side_on)
    else $error("pump fault did not pull low bit");
  ot_code_a: assert property (ot && i_shutdown_n |-> ##3 o_fault_code_low_bit_oe
    && o_fault_code_high_bit_oe && o_low_side_on) else $error("thermal code missing");
  mute_ground_a: assert property (!i_mute_n && i_shutdown_n |-> ##3 o_low_side_on && !o_amp_enable)
    else $error("mute did not ground load");
  shutdown_mode_a: assert property (!i_shutdown_n |-> ##3 o_shutdown_mode && !o_low_side_on
    && !o_amp_enable) else $error("shutdown not entered");
  run_cause_a: assert property (o_amp_enable |-> $past(i_mute_n, 3) && $past(i_shutdown_n, 3)
    && !$past(ot, 3) && !$past(uv, 3)) else $error("run without clean inputs");
  low_hold_a: assert property ((o_fault_code_low_bit_oe && i_mute_n && i_shutdown_n && quiet)[*4]
    |=> o_fault_code_low_bit_oe) else $error("low bit lost without host cycle");
  high_hold_a: assert property ((o_fault_code_high_bit_oe && i_mute_n && i_shutdown_n && quiet)[*4]
    |=> o_fault_code_high_bit_oe) else $error("high bit lost without host cycle");
  code_clear_a: assert property ($rose(i_mute_n) ##0 (!ot && !uv)[*3]
    |=> !o_fault_code_low_bit_oe && !o_fault_code_high_bit_oe) else $error("code not cleared");
  // apb answer: zero wait states, error only off the map
  apb_ready_a: assert property (i_psel && !i_penable ##1 i_psel && i_penable |-> o_pready)
    else $error("no ready in access cycle");
  apb_error_a: assert property (i_psel && i_penable && o_pready
    |-> o_pslverr == (i_paddr > `AMP_ADDR_EVENTS || i_paddr[1:0] != 2'h0))
    else $error("error flag wrong");

  // ==========================================================
  // scenario coverage
  uv_seen_c: cover property (uv && !ot ##3 o_fault_code_low_bit_oe);
  ot_seen_c: cover property (ot ##3 o_fault_code_high_bit_oe);
  clear_seen_c: cover property (o_fault_code_low_bit_oe ##1 !o_fault_code_low_bit_oe);
  slverr_seen_c: cover property (o_pslverr && o_pready);
endmodule : amp_fault_mute_control_asserts

bind amp_fault_mute_control amp_fault_mute_control_asserts u_chk (
  .i_mclk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_pslverr,
  .i_mute_n, .i_shutdown_n, .i_overtemp, .i_pump_undervoltage_fault,
  .o_fault_code_low_bit_oe, .o_fault_code_high_bit_oe, .o_low_side_on, .o_amp_enable,
  .o_shutdown_mode
);

/* tb/host_ctrl_model.sv */
`timescale 1ns/10ps

// ==========================================================
// host side: drives mute and shutdown, pulls up the fault wires
module host_ctrl_model (
  // clock
  input  wire logic i_mclk,
  // open-drain enables from the amplifier
  input  wire logic i_low_oe,
  input  wire logic i_high_oe,
  // host pins and resolved wires
  output logic      o_mute_n,
  output logic      o_shutdown_n,
  output logic      o_pin_low,
  output logic      o_pin_high
);
  // pull-up resistors: a released wire reads high, never a stale level
  assign o_pin_low  = !i_low_oe;
  assign o_pin_high = !i_high_oe;

  // idle host keeps the amplifier running
  initial
  begin
    o_mute_n     = 1'h1;
    o_shutdown_n = 1'h1;
  end

  task drive(input logic m, input logic s);
    @(posedge i_mclk);
    o_mute_n     <= m;
    o_shutdown_n <= s;
  endtask : drive
endmodule : host_ctrl_model

/* tb/testbench.sv */
`timescale 1ns/10ps
`include "amp_params.svh"

// ==========================================================
// bench for the fault and mute core
module testbench;
  logic        i_mclk, i_arst_n, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0]  i_pstrb;
  logic        o_pready, o_pslverr, err, mute_n, shutdown_n, ot, uv;
  logic        pin_lo, pin_hi, oe_lo, oe_hi, drv_lo, drv_hi;
  logic        low_side_on, amp_enable, shutdown_mode;
  int          err_count;
  int          cmp_count;
  // rows: {mute_n,shdn_n,ot,uv}, {0,low_side,enable,shutdown}, {high,low} code
  logic [11:0] rows [15] = '{12'hc23, 12'h443, 12'hc23, 12'hd42, 12'hc22, 12'hf40, 12'hc20,
                             12'h810, 12'hc23, 12'he40, 12'h440, 12'hc23, 12'h542, 12'hd42,
                             12'hc22};

  amp_fault_mute_control u_dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_mute_n(mute_n), .i_shutdown_n(shutdown_n), .i_overtemp(ot),
    .i_pump_undervoltage_fault(uv), .i_fault_code_low_bit(pin_lo),
    .o_fault_code_low_bit(drv_lo), .o_fault_code_low_bit_oe(oe_lo),
    .i_fault_code_high_bit(pin_hi), .o_fault_code_high_bit(drv_hi),
    .o_fault_code_high_bit_oe(oe_hi), .o_low_side_on(low_side_on),
    .o_amp_enable(amp_enable), .o_shutdown_mode(shutdown_mode)
  );

  host_ctrl_model u_host (
    .i_mclk(i_mclk), .i_low_oe(oe_lo), .i_high_oe(oe_hi), .o_mute_n(mute_n),
    .o_shutdown_n(shutdown_n), .o_pin_low(pin_lo), .o_pin_high(pin_hi)
  );

  // ==========================================================
  // clock and watchdog; whole run is well under a thousand cycles
  initial
  begin
    i_mclk = 1'h0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    err_count++;
    end_sim();
  end

  // ==========================================================
  // tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one apb transfer; only the watchdog bounds the wait for ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel    <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    do
    begin
      @(posedge i_mclk);
    end
    while (o_pready !== 1'h1);
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'h0;
    i_penable <= 1'h0;
  endtask : apb

  // wait out sync plus state latency, then look at the code pins
  task settle_code(input logic [1:0] exp);
    repeat (4) @(posedge i_mclk);
    chk("pins", {30'h0, pin_hi, pin_lo}, {30'h0, exp});
  endtask : settle_code

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // ==========================================================
  // main sequence
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    i_arst_n  = 1'h0;
    i_psel    = 1'h0;
    i_penable = 1'h0;
    i_pwrite  = 1'h0;
    i_paddr   = 12'h000;
    i_pwdata  = 32'h0;
    i_pstrb   = 4'hf;
    ot        = 1'h0;
    uv        = 1'h0;
    repeat (5) @(posedge i_mclk);
    chk("reset_oe", {30'h0, oe_hi, oe_lo}, 32'h0);
    chk("reset_drv", {30'h0, drv_hi, drv_lo}, 32'h0);
    i_arst_n <= 1'h1;
    apb(1'h0, `AMP_ADDR_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    // table of pin and fault cases
    foreach (rows[i])
    begin
      u_host.drive(rows[i][11], rows[i][10]);
      ot <= rows[i][9];
      uv <= rows[i][8];
      settle_code(rows[i][1:0]);
      chk("power", {29'h0, low_side_on, amp_enable, shutdown_mode}, {29'h0, rows[i][6:4]});
      apb(1'h0, `AMP_ADDR_STATUS, 32'h0);
      chk("status_code", {24'h0, rd[7:0]}, {24'h0, rows[i][1:0], rows[i][10], rows[i][11],
          rows[i][9:8], rows[i][1:0]});
    end
    // unmapped word is refused with zero data
    apb(1'h0, 12'h00c, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("unmapped", rd, 32'h0);
    // rising fault edges seen by the table: pump three, thermal two
    apb(1'h0, `AMP_ADDR_EVENTS, 32'h0);
    chk("events", rd, 32'h0000_0203);
    apb(1'h1, `AMP_ADDR_EVENTS, 32'h0);
    apb(1'h0, `AMP_ADDR_EVENTS, 32'h0);
    chk("events_clr", rd, 32'h0);
    // a control write without byte lane 0 must not land
    i_pstrb <= 4'h0;
    apb(1'h1, `AMP_ADDR_CTRL, 32'h1);
    i_pstrb <= 4'hf;
    apb(1'h0, `AMP_ADDR_CTRL, 32'h0);
    chk("strb_gate", rd, 32'h0);
    // soft mute from the register grounds the load
    apb(1'h1, `AMP_ADDR_CTRL, 32'h1);
    repeat (4) @(posedge i_mclk);
    chk("soft_mute", {29'h0, low_side_on, amp_enable, shutdown_mode}, 32'h4);
    apb(1'h0, `AMP_ADDR_CTRL, 32'h0);
    chk("ctrl_rb", rd, 32'h1);
    apb(1'h1, `AMP_ADDR_CTRL, 32'h0);
    // clear refused while thermal live, taken once it goes
    ot <= 1'h1;
    settle_code(2'h0);
    apb(1'h1, `AMP_ADDR_CTRL, 32'h2);
    settle_code(2'h0);
    ot <= 1'h0;
    settle_code(2'h0);
    apb(1'h1, `AMP_ADDR_CTRL, 32'h2);
    settle_code(2'h3);
    // power cycle drops a retained code
    uv <= 1'h1;
    settle_code(2'h2);
    uv <= 1'h0;
    settle_code(2'h2);
    i_arst_n <= 1'h0;
    repeat (2) @(posedge i_mclk);
    chk("rst_shdn", {31'h0, shutdown_mode}, 32'h1);
    i_arst_n <= 1'h1;
    settle_code(2'h3);
    end_sim();
  end
endmodule : testbench
